// ==== verilog/ocm_pkg.sv ====
package ocm_pkg;
  // Register offsets
  localparam logic [7:0] OCM_STOP_CTRL_ADDR = 8'h38;
  localparam logic [7:0] OCM_OSC_HALT_ADDR = 8'h39;
  localparam logic [7:0] OCM_WAKE_EN_ADDR = 8'h31;
  // Oscillator and halt control fields
  localparam int OCM_FAST_EN_BIT = 7;
  localparam int OCM_SLOW_EN_BIT = 6;
  localparam int OCM_CLK_SEL_BIT = 5;
  localparam int OCM_CPU_STOP_BIT = 4;
  localparam int OCM_PER_HALT_BIT = 2;
  localparam logic [7:0] OCM_OSC_HALT_RST = 8'h80;
  // Stop mode control fields
  localparam int OCM_STOP_BIT = 7;
  localparam int OCM_RELEASE_METHOD_BIT = 6;
  localparam int OCM_RETURN_MODE_SELECT_BIT = 5;
  localparam int OCM_OUTEN_BIT = 4;
  localparam int OCM_WUT_LSB = 2;
  localparam logic [7:0] OCM_STOP_CTRL_RST = 8'h00;
  localparam logic [3:0] OCM_WAKE_EN_RST = 4'h0;
  // Warm-up lengths in oscillator periods
  localparam int OCM_WU_FAST_0 = 3 * (2 ** 16);
  localparam int OCM_WU_FAST_1 = 2 ** 16;
  localparam int OCM_WU_FAST_2 = 3 * (2 ** 14);
  localparam int OCM_WU_FAST_3 = 2 ** 14;
  localparam int OCM_WU_SLOW_0 = 3 * (2 ** 13);
  localparam int OCM_WU_SLOW_1 = 2 ** 13;
  localparam int OCM_WU_SLOW_2 = 3 * (2 ** 6);
  localparam int OCM_WU_SLOW_3 = 2 ** 6;
  // Stop sequencer states, Gray along run-stop-warm
  typedef enum logic [1:0] {
    OCM_RUN = 2'b00,
    OCM_STOP = 2'b01,
    OCM_WARM = 2'b11
  } ocm_state_t;
endpackage

// ==== verilog/ocm_ctrl.sv ====
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module ocm_ctrl import ocm_pkg::*; #(
  parameter int WU_F0 = OCM_WU_FAST_0,
  parameter int WU_F1 = OCM_WU_FAST_1,
  parameter int WU_F2 = OCM_WU_FAST_2,
  parameter int WU_F3 = OCM_WU_FAST_3,
  parameter int WU_S0 = OCM_WU_SLOW_0,
  parameter int WU_S1 = OCM_WU_SLOW_1,
  parameter int WU_S2 = OCM_WU_SLOW_2,
  parameter int WU_S3 = OCM_WU_SLOW_3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic stop_pin,
  input wire logic [3:0] key_wakeup_inputs,
  input wire logic idle_release,
  input wire logic tb_release,
  output logic fast_osc_on,
  output logic slow_osc_on,
  output logic main_clock_select,
  output logic cpu_halt,
  output logic wdt_halt,
  output logic periph_clock_halt,
  output logic stop_active,
  output logic warmup_active,
  output logic divider_clear,
  output logic port_output_keep,
  output logic sys_reset_req
);

  // Counter width covers the longest warm-up
  localparam int CW = 18;

  // Refuse lengths the counter cannot hold, at elaboration
  if (WU_F0 < 1 || WU_F0 >= 2 ** CW || WU_S0 < 1 || WU_S0 >= 2 ** CW ||
      WU_F1 < 1 || WU_F2 < 1 || WU_F3 < 1 || WU_S1 < 1 || WU_S2 < 1 ||
      WU_S3 < 1 || WU_F1 >= 2 ** CW || WU_F2 >= 2 ** CW ||
      WU_F3 >= 2 ** CW || WU_S1 >= 2 ** CW || WU_S2 >= 2 ** CW ||
      WU_S3 >= 2 ** CW) begin : g_bad_len
    $error("ocm_ctrl: warm-up length out of range");
  end

  // Register state
  logic [7:0] osc_ctl_ff; // Oscillator and halt control
  logic [7:0] stop_ctl_ff; // Stop mode control
  logic [3:0] wake_en_ff; // Key wakeup enables
  logic level_eff_ff; // Release method in force
  ocm_state_t state_ff; // Stop sequencer
  ocm_state_t nxt_state;
  logic [CW-1:0] wu_cnt_ff; // Warm-up divider
  logic [CW-1:0] wu_len; // Selected warm-up length
  // Pin synchronisers
  logic stop_meta_ff;
  logic stop_sync_ff;
  logic stop_prev_ff;
  logic [3:0] key_meta_ff;
  logic [3:0] key_sync_ff;
  // Decodes
  logic wr_osc;
  logic wr_stop;
  logic stop_rise;
  logic level_cond;
  logic release_now;
  logic warm_done;
  logic osc_fault;

  assign wr_osc = reg_wr && (reg_addr == OCM_OSC_HALT_ADDR);
  assign wr_stop = reg_wr && (reg_addr == OCM_STOP_CTRL_ADDR);
  assign stop_rise = stop_sync_ff && !stop_prev_ff;
  // Pin high or any enabled key low
  assign level_cond = stop_sync_ff ||
                      (|(wake_en_ff & ~key_sync_ff));
  // Keys take no part in edge release
  assign release_now = level_eff_ff ? level_cond : stop_rise;
  assign warm_done = (wu_cnt_ff == wu_len - 18'h00001);

  // Clock-in-use check on oscillator writes
  always_comb begin
    osc_fault = 1'b0;
    if (!reg_wdata[OCM_FAST_EN_BIT] && !reg_wdata[OCM_SLOW_EN_BIT]) begin
      osc_fault = 1'b1;
    end else if (!reg_wdata[OCM_CLK_SEL_BIT]) begin
      osc_fault = !reg_wdata[OCM_FAST_EN_BIT];
    end else begin
      osc_fault = !reg_wdata[OCM_SLOW_EN_BIT];
    end
  end

  // Warm-up length from field and return mode
  always_comb begin
    case ({stop_ctl_ff[OCM_RETURN_MODE_SELECT_BIT], stop_ctl_ff[OCM_WUT_LSB +: 2]})
      3'b000: wu_len = CW'(WU_F0);
      3'b001: wu_len = CW'(WU_F1);
      3'b010: wu_len = CW'(WU_F2);
      3'b011: wu_len = CW'(WU_F3);
      3'b100: wu_len = CW'(WU_S0);
      3'b101: wu_len = CW'(WU_S1);
      3'b110: wu_len = CW'(WU_S2);
      default: wu_len = CW'(WU_S3);
    endcase
  end

  // Two-stage pin synchronisers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stop_meta_ff <= 1'b0;
      stop_sync_ff <= 1'b0;
      stop_prev_ff <= 1'b0;
      key_meta_ff <= 4'hf;
      key_sync_ff <= 4'hf;
    end else begin
      stop_meta_ff <= stop_pin;
      stop_sync_ff <= stop_meta_ff;
      stop_prev_ff <= stop_sync_ff;
      key_meta_ff <= key_wakeup_inputs;
      key_sync_ff <= key_meta_ff;
    end
  end

  // Stop sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      OCM_RUN: begin
        if (wr_stop && reg_wdata[OCM_STOP_BIT]) begin
          // Level mode with release present skips stop
          if (level_eff_ff && level_cond) begin
            nxt_state = OCM_WARM;
          end else begin
            nxt_state = OCM_STOP;
          end
        end
      end
      OCM_STOP: begin
        if (release_now) begin
          nxt_state = OCM_WARM;
        end
      end
      OCM_WARM: begin
        // Only the terminal count leaves warm-up
        if (warm_done) begin
          nxt_state = OCM_RUN;
        end
      end
      default: nxt_state = OCM_RUN;
    endcase
  end

  // Sequencer state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= OCM_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Warm-up divider, cleared whenever not in warm-up
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wu_cnt_ff <= '0;
    end else if (state_ff != OCM_WARM) begin
      wu_cnt_ff <= '0;
    end else if (!warm_done) begin
      wu_cnt_ff <= wu_cnt_ff + 18'h00001;
    end
  end

  // Release method in force
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_eff_ff <= 1'b0;
    end else if (!stop_ctl_ff[OCM_RELEASE_METHOD_BIT]) begin
      level_eff_ff <= 1'b0;
    end else if (!level_eff_ff && stop_rise) begin
      level_eff_ff <= 1'b1;
    end
  end

  // Stop mode control register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stop_ctl_ff <= OCM_STOP_CTRL_RST;
    end else if (wr_stop && state_ff == OCM_RUN) begin
      stop_ctl_ff <= reg_wdata;
    end else if (state_ff == OCM_WARM && warm_done) begin
      stop_ctl_ff[OCM_STOP_BIT] <= 1'b0;
    end
  end

  // Key wakeup enable register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_en_ff <= OCM_WAKE_EN_RST;
    end else if (reg_wr && reg_addr == OCM_WAKE_EN_ADDR) begin
      wake_en_ff <= reg_wdata[3:0];
    end
  end

  // Oscillator and halt control register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_ctl_ff <= OCM_OSC_HALT_RST;
    end else if (state_ff == OCM_WARM && warm_done) begin
      // Return mode decides the clock after stop
      if (stop_ctl_ff[OCM_RETURN_MODE_SELECT_BIT]) begin
        osc_ctl_ff[OCM_CLK_SEL_BIT] <= 1'b1;
        osc_ctl_ff[OCM_SLOW_EN_BIT] <= 1'b1;
      end else begin
        osc_ctl_ff[OCM_CLK_SEL_BIT] <= 1'b0;
        osc_ctl_ff[OCM_FAST_EN_BIT] <= 1'b1;
      end
    end else if (wr_osc) begin
      // Undefined bits are not stored
      osc_ctl_ff <= reg_wdata & 8'hf4;
    end else begin
      if (idle_release) begin
        osc_ctl_ff[OCM_CPU_STOP_BIT] <= 1'b0;
      end
      // Accepted in any cycle without an oscillator write or warm-up end, so the halt may be short
      if (tb_release) begin
        osc_ctl_ff[OCM_PER_HALT_BIT] <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fast_osc_on <= 1'b1;
      slow_osc_on <= 1'b0;
      main_clock_select <= 1'b0;
      cpu_halt <= 1'b0;
      wdt_halt <= 1'b0;
      periph_clock_halt <= 1'b0;
      stop_active <= 1'b0;
      warmup_active <= 1'b0;
      divider_clear <= 1'b0;
      port_output_keep <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      // Oscillators off in stop; warm-up restarts the return-mode one, slow also if enabled
      fast_osc_on <= (state_ff == OCM_STOP) ? 1'b0 :
                     (state_ff == OCM_WARM) ?
                     !stop_ctl_ff[OCM_RETURN_MODE_SELECT_BIT] :
                     osc_ctl_ff[OCM_FAST_EN_BIT];
      slow_osc_on <= (state_ff == OCM_STOP) ? 1'b0 :
                     (state_ff == OCM_WARM) ?
                     (stop_ctl_ff[OCM_RETURN_MODE_SELECT_BIT] |
                      osc_ctl_ff[OCM_SLOW_EN_BIT]) :
                     osc_ctl_ff[OCM_SLOW_EN_BIT];
      main_clock_select <= osc_ctl_ff[OCM_CLK_SEL_BIT];
      // Program counter and state held while halted
      cpu_halt <= osc_ctl_ff[OCM_CPU_STOP_BIT] ||
                  (state_ff != OCM_RUN);
      wdt_halt <= osc_ctl_ff[OCM_CPU_STOP_BIT] ||
                  (state_ff != OCM_RUN);
      periph_clock_halt <= osc_ctl_ff[OCM_PER_HALT_BIT] ||
                           (state_ff != OCM_RUN);
      stop_active <= (state_ff == OCM_STOP);
      warmup_active <= (state_ff == OCM_WARM);
      divider_clear <= (state_ff == OCM_STOP);
      port_output_keep <= stop_ctl_ff[OCM_OUTEN_BIT];
      sys_reset_req <= wr_osc && osc_fault;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OCM_OSC_HALT_ADDR: reg_rdata <= osc_ctl_ff & 8'hf4;
        OCM_STOP_CTRL_ADDR: reg_rdata <= stop_ctl_ff & 8'hfc;
        OCM_WAKE_EN_ADDR: reg_rdata <= {4'h0, wake_en_ff};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_reset_fault;
    wr_osc && osc_fault |=> sys_reset_req;
  endproperty
  a_reset_fault: assert property (p_reset_fault)
    else $error("clock fault write gave no reset request");

  property p_no_false_reset;
    !(wr_osc && osc_fault) |=> !sys_reset_req;
  endproperty
  a_no_false_reset: assert property (p_no_false_reset)
    else $error("reset request without a clock fault");

  property p_idle_clear;
    idle_release && !wr_osc && state_ff != OCM_WARM
      |=> !osc_ctl_ff[OCM_CPU_STOP_BIT] ##1 !cpu_halt || state_ff != OCM_RUN;
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("idle release did not clear the cpu stop bit");

  property p_tb_clear;
    tb_release && !wr_osc && state_ff != OCM_WARM
      |=> !osc_ctl_ff[OCM_PER_HALT_BIT];
  endproperty
  a_tb_clear: assert property (p_tb_clear)
    else $error("timebase release did not clear the halt bit");

  property p_level_skip;
    state_ff == OCM_RUN && wr_stop && reg_wdata[OCM_STOP_BIT] &&
      level_eff_ff && level_cond |=> state_ff == OCM_WARM;
  endproperty
  a_level_skip: assert property (p_level_skip)
    else $error("level start with release present entered stop");

  property p_edge_enter;
    state_ff == OCM_RUN && wr_stop && reg_wdata[OCM_STOP_BIT] &&
      !level_eff_ff |=> state_ff == OCM_STOP;
  endproperty
  a_edge_enter: assert property (p_edge_enter)
    else $error("edge mode start did not enter stop");

  property p_warm_stays;
    state_ff == OCM_WARM |=> state_ff != OCM_STOP;
  endproperty
  a_warm_stays: assert property (p_warm_stays)
    else $error("warm-up went back to stop");

  property p_edge_only;
    state_ff == OCM_STOP && !level_eff_ff && !stop_rise
      |=> state_ff == OCM_STOP;
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("edge mode left stop without a rising edge");

  property p_osc_off;
    state_ff == OCM_STOP |=> !fast_osc_on && !slow_osc_on && cpu_halt;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator running during stop");

  property p_div_cleared;
    $rose(state_ff == OCM_WARM) |-> wu_cnt_ff == '0;
  endproperty
  a_div_cleared: assert property (p_div_cleared)
    else $error("warm-up divider not cleared");

  property p_warm_end;
    state_ff == OCM_WARM && warm_done |=> state_ff == OCM_RUN ##1 !stop_active;
  endproperty
  a_warm_end: assert property (p_warm_end)
    else $error("warm-up did not end at terminal count");

  property p_switch_wait;
    !level_eff_ff && !stop_rise |=> !level_eff_ff;
  endproperty
  a_switch_wait: assert property (p_switch_wait)
    else $error("release method switched without rising edge");

  c_stop_edge: cover property (state_ff == OCM_STOP && stop_rise);
  c_level_skip: cover property (
    state_ff == OCM_RUN && nxt_state == OCM_WARM);
  c_warm_done: cover property (state_ff == OCM_WARM && warm_done);
  c_fault: cover property (sys_reset_req);

endmodule

// ==== test/ocm_wake_model.sv ====
`timescale 1ns/10ps
// Far side of the stop link: the stop pin and the key wakeup pins
module ocm_wake_model (
  input wire logic sys_clk,
  output logic stop_pin,
  output logic [3:0] key_wakeup_inputs
);
  // Pin starts low, keys idle high (active low)
  initial begin
    stop_pin = 1'b0;
    key_wakeup_inputs = 4'hf;
  end

  // Pin level, changed just after an edge
  task set_pin(input logic v);
    @(posedge sys_clk);
    stop_pin <= v;
  endtask

  // Key levels; pulled low only in level release
  task set_keys(input logic [3:0] v);
    @(posedge sys_clk);
    key_wakeup_inputs <= v;
  endtask

  // Low long enough to sync, then a clean rising edge
  task edge_release;
    set_pin(1'b0);
    repeat (4) @(posedge sys_clk);
    set_pin(1'b1);
  endtask
endmodule

// ==== test/ocm_ctrl_tb_top.sv ====
`timescale 1ns/10ps
module ocm_ctrl_tb_top;
  import ocm_pkg::*;
  logic sys_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic idle_release;
  logic tb_release;
  logic [7:0] reg_rdata;
  logic stop_pin;
  logic [3:0] keys;
  logic fast_osc_on, slow_osc_on, main_clock_select, cpu_halt, wdt_halt;
  logic periph_clock_halt, stop_active, warmup_active, divider_clear;
  logic port_output_keep, sys_reset_req;
  int bad_count = 0;
  int comparisons = 0;
  logic saw_stop;
  int n;
  logic [1:0] w;
  logic r;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // Long lengths shortened; slow fields 1 to 3 keep their own
  ocm_ctrl #(.WU_F0(8), .WU_F1(6), .WU_F2(4), .WU_F3(3),
    .WU_S0(7)) DUT (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stop_pin(stop_pin),
    .key_wakeup_inputs(keys), .idle_release(idle_release),
    .tb_release(tb_release), .fast_osc_on(fast_osc_on),
    .slow_osc_on(slow_osc_on), .main_clock_select(main_clock_select),
    .cpu_halt(cpu_halt), .wdt_halt(wdt_halt),
    .periph_clock_halt(periph_clock_halt), .stop_active(stop_active),
    .warmup_active(warmup_active), .divider_clear(divider_clear),
    .port_output_keep(port_output_keep), .sys_reset_req(sys_reset_req));

  // Stop pin and key pins
  ocm_wake_model partner (.sys_clk(sys_clk), .stop_pin(stop_pin),
    .key_wakeup_inputs(keys));

  // Verdict and end of run
  task summarize;
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Single compare point
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  // One-cycle register write
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read, masked compare; data stand one cycle after strobe
  task rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check(reg_rdata & m, e);
  endtask

  // Let a write reach the outputs
  task settle;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Wait condition selector
  function logic pick(input int sel);
    case (sel)
      0: return stop_active;
      1: return warmup_active;
      default: return !warmup_active && !stop_active;
    endcase
  endfunction

  // Bounded wait, noting any stop state seen
  task wait_on(input int sel);
    int k;
    k = 0;
    @(negedge sys_clk);
    saw_stop = saw_stop | stop_active;
    while (!pick(sel) && k < 40) begin
      k++;
      @(negedge sys_clk);
      saw_stop = saw_stop | stop_active;
    end
    if (k == 40) begin
      bad_count++;
      $display("BAD %0t wait %0d ran out", $time, sel);
      summarize;
    end
  endtask

  // Clock-fault write, reset pulse expected or not
  task fault(input logic [7:0] d, input logic e);
    wr(OCM_OSC_HALT_ADDR, d);
    @(negedge sys_clk);
    chk1(sys_reset_req, e);
  endtask

  // Expected warm-up cycles for field and return mode
  function int wu_len(input logic [1:0] f, input logic s);
    case ({s, f})
      3'b000: return 8;
      3'b001: return 6;
      3'b010: return 4;
      3'b011: return 3;
      3'b100: return 7;
      3'b101: return OCM_WU_SLOW_1;
      3'b110: return OCM_WU_SLOW_2;
      default: return OCM_WU_SLOW_3;
    endcase
  endfunction

  // Warm-up length, halt and return clock
  task warm_check(input int len, input logic s);
    wait_on(1);
    chk1(s ? slow_osc_on : fast_osc_on, 1'b1);
    chk1(cpu_halt, 1'b1);
    n = 0;
    while (warmup_active && n < 9000) begin
      n++;
      @(negedge sys_clk);
    end
    chk1(n == len, 1'b1);
    chk1(cpu_halt, 1'b0);
    chk1(main_clock_select, s);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    idle_release = 1'b0;
    tb_release = 1'b0;
    saw_stop = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, undefined bits masked
    rdchk(OCM_OSC_HALT_ADDR, 8'hf4, 8'h80);
    rdchk(OCM_STOP_CTRL_ADDR, 8'hfc, 8'h00);
    rdchk(8'h00, 8'hff, 8'h00);
    // Clock-fault writes
    fault(8'h40, 1'b1);
    wr(OCM_OSC_HALT_ADDR, 8'hc0);
    fault(8'h00, 1'b1);
    wr(OCM_OSC_HALT_ADDR, 8'hc0);
    fault(8'he0, 1'b0);
    settle;
    chk1(slow_osc_on, 1'b1);
    chk1(main_clock_select, 1'b1);
    rdchk(OCM_OSC_HALT_ADDR, 8'hf4, 8'he0);
    fault(8'ha0, 1'b1);
    wr(OCM_OSC_HALT_ADDR, 8'hc0);
    settle;
    chk1(main_clock_select, 1'b0);
    // CPU stop and its release; never both halt bits
    wr(OCM_OSC_HALT_ADDR, 8'hd0);
    settle;
    chk1(cpu_halt & wdt_halt, 1'b1);
    chk1(periph_clock_halt, 1'b0);
    @(posedge sys_clk);
    idle_release <= 1'b1;
    @(posedge sys_clk);
    idle_release <= 1'b0;
    settle;
    chk1(cpu_halt, 1'b0);
    rdchk(OCM_OSC_HALT_ADDR, 8'hf4, 8'hc0);
    // Peripheral halt and its release
    wr(OCM_OSC_HALT_ADDR, 8'hc4);
    settle;
    chk1(periph_clock_halt, 1'b1);
    chk1(cpu_halt, 1'b0);
    @(posedge sys_clk);
    tb_release <= 1'b1;
    @(posedge sys_clk);
    tb_release <= 1'b0;
    settle;
    chk1(periph_clock_halt, 1'b0);
    rdchk(OCM_OSC_HALT_ADDR, 8'hf4, 8'hc0);
    // Edge release, every field and return mode, pin high at start
    partner.set_pin(1'b1);
    // Let the rising edge pass the synchroniser before stopping
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      w = 2'(i % 4);
      r = (i >= 4);
      wr(OCM_STOP_CTRL_ADDR, {2'b10, r, 1'b0, w, 2'b00});
      wait_on(0);
      chk1(cpu_halt & divider_clear, 1'b1);
      chk1(fast_osc_on | slow_osc_on, 1'b0);
      chk1(periph_clock_halt, 1'b1);
      repeat (6) @(negedge sys_clk);
      chk1(stop_active, 1'b1);
      partner.edge_release();
      warm_check(wu_len(w, r), r);
      rdchk(OCM_STOP_CTRL_ADDR, 8'h80, 8'h00);
    end
    // Level chosen without a new edge still acts as edge
    wr(OCM_STOP_CTRL_ADDR, 8'h50);
    settle;
    chk1(port_output_keep, 1'b1);
    wr(OCM_STOP_CTRL_ADDR, 8'hc0);
    wait_on(0);
    chk1(stop_active, 1'b1);
    partner.edge_release();
    warm_check(8, 1'b0);
    // Level start with pin high goes straight to warm-up
    saw_stop = 1'b0;
    wr(OCM_STOP_CTRL_ADDR, 8'hc0);
    wait_on(1);
    chk1(saw_stop, 1'b0);
    wait_on(2);
    // Enabled key low releases, disabled key does not
    partner.set_pin(1'b0);
    wr(OCM_WAKE_EN_ADDR, 8'h04);
    rdchk(OCM_WAKE_EN_ADDR, 8'h0f, 8'h04);
    partner.set_keys(4'he);
    repeat (4) @(posedge sys_clk);
    wr(OCM_STOP_CTRL_ADDR, 8'hc0);
    wait_on(0);
    repeat (6) @(negedge sys_clk);
    chk1(stop_active, 1'b1);
    partner.set_keys(4'ha);
    warm_check(8, 1'b0);
    partner.set_keys(4'hf);
    // Pin level release, pin dropped during warm-up
    repeat (4) @(posedge sys_clk);
    wr(OCM_STOP_CTRL_ADDR, 8'hc0);
    wait_on(0);
    partner.set_pin(1'b1);
    wait_on(1);
    partner.set_pin(1'b0);
    wait_on(2);
    repeat (8) @(negedge sys_clk);
    chk1(stop_active, 1'b0);
    summarize;
  end
endmodule
